// ---- rtl/mpc_pkg.sv ----
// constants, types and register map of the multimode period counter
// assumes a classic wishbone master with 32-bit data and byte selects
package mpc_pkg;
    localparam int NUM_CMP = 7;
    localparam int CW = 16;

    // timer clock made from ref_clk: rising edge when divider returns to zero
    localparam logic [1:0] DIV_LAST = 2'h3;
    localparam logic [1:0] DIV_HIGH = 2'h2;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_COUNT = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_IE = 8'h0c;
    localparam logic [7:0] ADR_LOAD = 8'h10;
    localparam logic [7:0] ADR_CMP_BASE = 8'h20;
    localparam logic [7:0] ADR_STEP = 8'h04;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LEN_LSB = 2;
    localparam int CTRL_CLR_BIT = 4;
    localparam int CTRL_GLOB_IE_BIT = 5;
    localparam int CTRL_DEFER_BIT = 6;
    localparam int STAT_DIR_BIT = 8;

    localparam logic [CW-1:0] MAX16 = 16'hffff;
    localparam logic [CW-1:0] MAX12 = 16'h0fff;
    localparam logic [CW-1:0] MAX10 = 16'h03ff;
    localparam logic [CW-1:0] MAX8 = 16'h00ff;
    localparam logic [CW-1:0] ZERO = 16'h0000;
    localparam logic [CW-1:0] ONE = 16'h0001;

    typedef enum logic [1:0] {
        MODE_STOP = 2'h0,
        MODE_UP = 2'h1,
        MODE_CONT = 2'h2,
        MODE_UPDN = 2'h3
    } mpc_mode_t;

    typedef enum logic [1:0] {
        LEN_16 = 2'h0,
        LEN_12 = 2'h1,
        LEN_10 = 2'h2,
        LEN_8 = 2'h3
    } mpc_len_t;

    typedef struct packed {
        logic [CW-1:0] buffer;
        logic [CW-1:0] latch;
        logic match;
    } mpc_cmp_state_t;

    typedef struct packed {
        mpc_mode_t mode;
        mpc_len_t len;
        logic glob_ie;
        logic defer;
        logic [CW-1:0] count;
        logic dir_down;
        logic [1:0] div;
        logic [CW-1:0] eff_period;
        logic [CW-1:0] prev_latch0;
        logic pend;
        logic [CW-1:0] pend_val;
        logic wrap_flag;
        logic [NUM_CMP-1:0] cmp_flag;
        logic [NUM_CMP:0] ie;
        logic ack;
        logic [31:0] dat;
    } mpc_state_t;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (d & m);
    endfunction

    function automatic logic [CW-1:0] len_max(input mpc_len_t len);
        logic [CW-1:0] r;
        r = MAX16;
        unique case (len)
            LEN_16: r = MAX16;
            LEN_12: r = MAX12;
            LEN_10: r = MAX10;
            LEN_8: r = MAX8;
        endcase
        return r;
    endfunction
endpackage

// ---- rtl/mpc_cmp_unit.sv ----
// one compare block: buffer, latch and equality event
// assumes count and its next value come from the counter core
`timescale 1ns/1ps
module mpc_cmp_unit (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic buf_wr,
    input wire logic [mpc_pkg::CW-1:0] buf_data,
    input wire logic defer,
    input wire logic group_load,
    input wire logic advance,
    input wire logic [mpc_pkg::CW-1:0] count,
    input wire logic [mpc_pkg::CW-1:0] count_next,
    output logic [mpc_pkg::CW-1:0] buffer,
    output logic [mpc_pkg::CW-1:0] latch,
    output logic match
);
    mpc_pkg::mpc_cmp_state_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.match = 1'b0;
        if (buf_wr) begin
            s_next.buffer = buf_data;
            if (!defer) begin
                s_next.latch = buf_data;
            end
        end
        if (group_load) begin
            s_next.latch = s_reg.buffer;
        end
        // event when the counter steps onto the latch value
        if (advance && count_next == s_reg.latch && count_next != count) begin
            s_next.match = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign buffer = s_reg.buffer;
    assign latch = s_reg.latch;
    assign match = s_reg.match;
endmodule

// ---- rtl/mpc_timer.sv ----
// counter core of the multimode period counter with wishbone registers
// assumes a classic wishbone master on ref_clk; one wait state per access
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module mpc_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    output logic [mpc_pkg::NUM_CMP-1:0] cmp_event
);
    mpc_pkg::mpc_state_t s_reg, s_next;

    logic [mpc_pkg::CW-1:0] cmp_buf [mpc_pkg::NUM_CMP];
    logic [mpc_pkg::CW-1:0] cmp_latch [mpc_pkg::NUM_CMP];
    logic [mpc_pkg::NUM_CMP-1:0] cmp_match;
    logic [mpc_pkg::NUM_CMP-1:0] cmp_wr;
    logic [mpc_pkg::NUM_CMP-1:0] load_mask;
    logic req;
    logic wr;
    logic clr;
    logic tick;
    logic advance;
    logic phase_high;
    logic [mpc_pkg::CW-1:0] mx;
    logic [mpc_pkg::CW-1:0] cnt_next;
    logic dir_next;
    logic [31:0] rdata;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] wdat;

    assign req = wb_cyc_i & wb_stb_i;
    // a write lands at the edge where ack is seen high
    assign wr = req & s_reg.ack & wb_we_i;
    assign mx = mpc_pkg::len_max(s_reg.len);
    assign clr = wr && wb_adr_i == mpc_pkg::ADR_CTRL && wb_sel_i[0]
        && wb_dat_i[mpc_pkg::CTRL_CLR_BIT];
    assign tick = s_reg.div == mpc_pkg::DIV_LAST && !clr;
    assign phase_high = s_reg.div < mpc_pkg::DIV_HIGH;
    assign advance = tick && s_reg.mode != mpc_pkg::MODE_STOP;
    assign load_mask = (wr && wb_adr_i == mpc_pkg::ADR_LOAD) ?
        wb_dat_i[mpc_pkg::NUM_CMP-1:0] : '0;

    assign ctrl_word = {25'h0000000, s_reg.defer, s_reg.glob_ie, 1'b0, s_reg.len, s_reg.mode};
    assign stat_word = {23'h000000, s_reg.dir_down, s_reg.cmp_flag, s_reg.wrap_flag};

    // next count and direction for one timer clock rising edge
    always_comb begin
        logic [mpc_pkg::CW-1:0] c;
        logic [mpc_pkg::CW-1:0] per;
        logic over;
        c = s_reg.count & mx;
        per = s_reg.eff_period;
        over = per > mx;
        cnt_next = c;
        dir_next = s_reg.dir_down;
        unique case (s_reg.mode)
            mpc_pkg::MODE_STOP: begin
                cnt_next = c;
            end
            mpc_pkg::MODE_UP: begin
                if (over || c >= per) begin
                    cnt_next = mpc_pkg::ZERO;
                end else begin
                    cnt_next = c + mpc_pkg::ONE;
                end
            end
            mpc_pkg::MODE_CONT: begin
                // starts from whatever the count holds
                cnt_next = (c == mx) ? mpc_pkg::ZERO : c + mpc_pkg::ONE;
            end
            mpc_pkg::MODE_UPDN: begin
                if (over) begin
                    cnt_next = (c == mx) ? mpc_pkg::ZERO : c + mpc_pkg::ONE;
                end else if (s_reg.dir_down) begin
                    // the period is not looked at until zero is reached
                    if (c == mpc_pkg::ZERO) begin
                        dir_next = 1'b0;
                        cnt_next = (per == mpc_pkg::ZERO) ? mpc_pkg::ZERO : mpc_pkg::ONE;
                    end else begin
                        cnt_next = c - mpc_pkg::ONE;
                    end
                end else if (c >= per) begin
                    dir_next = 1'b1;
                    cnt_next = (c == mpc_pkg::ZERO) ? mpc_pkg::ZERO : c - mpc_pkg::ONE;
                end else begin
                    cnt_next = c + mpc_pkg::ONE;
                end
            end
        endcase
        cnt_next = cnt_next & mx;
    end

    always_comb begin
        rdata = 32'h00000000;
        for (int i = 0; i < mpc_pkg::NUM_CMP; i++) begin
            if (wb_adr_i == mpc_pkg::ADR_CMP_BASE + 8'(i) * mpc_pkg::ADR_STEP) begin
                rdata = {16'h0000, cmp_buf[i]};
            end
        end
        unique case (wb_adr_i)
            mpc_pkg::ADR_CTRL: rdata = ctrl_word;
            mpc_pkg::ADR_COUNT: rdata = {16'h0000, s_reg.count & mx};
            mpc_pkg::ADR_STATUS: rdata = stat_word;
            mpc_pkg::ADR_IE: rdata = {24'h000000, s_reg.ie};
            default: begin
            end
        endcase
    end

    always_comb begin
        logic [31:0] w;
        w = 32'h00000000;
        s_next = s_reg;
        wdat = wb_dat_i;
        s_next.ack = req & ~s_reg.ack;
        if (req && !s_reg.ack) begin
            s_next.dat = rdata;
        end

        // timer clock divider
        if (clr) begin
            s_next.div = 2'h0;
        end else begin
            s_next.div = s_reg.div + 2'h1;
        end

        // edge of the timer clock: count, direction, flags
        if (advance) begin
            s_next.count = cnt_next;
            s_next.dir_down = dir_next;
            if ((s_reg.count & mx) != mpc_pkg::ZERO && cnt_next == mpc_pkg::ZERO) begin
                s_next.wrap_flag = 1'b1;
            end
        end
        if (tick && s_reg.pend) begin
            // the extra cycle under the old period is over
            s_next.eff_period = s_reg.pend_val;
            s_next.pend = 1'b0;
        end

        // period latch change into eff_period, at once or at the next tick
        s_next.prev_latch0 = cmp_latch[0];
        if (cmp_latch[0] != s_reg.prev_latch0) begin
            // low phase seen on the step cycle: this step is the extra one
            if (cmp_latch[0] >= s_reg.eff_period || phase_high || tick) begin
                s_next.eff_period = cmp_latch[0];
                s_next.pend = 1'b0;
            end else begin
                s_next.pend = 1'b1;
                s_next.pend_val = cmp_latch[0];
            end
        end

        // compare flags, set wins over clear
        s_next.cmp_flag = s_reg.cmp_flag | cmp_match;

        if (wr) begin
            unique case (wb_adr_i)
                mpc_pkg::ADR_CTRL: begin
                    w = mpc_pkg::merge(ctrl_word, wdat, wb_sel_i);
                    s_next.mode = mpc_pkg::mpc_mode_t'(w[mpc_pkg::CTRL_MODE_LSB +: 2]);
                    s_next.len = mpc_pkg::mpc_len_t'(w[mpc_pkg::CTRL_LEN_LSB +: 2]);
                    s_next.glob_ie = w[mpc_pkg::CTRL_GLOB_IE_BIT];
                    s_next.defer = w[mpc_pkg::CTRL_DEFER_BIT];
                end
                mpc_pkg::ADR_COUNT: begin
                    w = mpc_pkg::merge({16'h0000, s_reg.count}, wdat, wb_sel_i);
                    s_next.count = w[mpc_pkg::CW-1:0] & mx;
                end
                mpc_pkg::ADR_STATUS: begin
                    w = wdat & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
                    s_next.wrap_flag = (s_reg.wrap_flag & ~w[0]) | s_next.wrap_flag
                        & ~(w[0] & ~(advance && s_next.wrap_flag && !s_reg.wrap_flag));
                    s_next.cmp_flag = (s_reg.cmp_flag & ~w[mpc_pkg::NUM_CMP:1]) | cmp_match;
                end
                mpc_pkg::ADR_IE: begin
                    w = mpc_pkg::merge({24'h000000, s_reg.ie}, wdat, wb_sel_i);
                    s_next.ie = w[mpc_pkg::NUM_CMP:0];
                end
                default: begin
                end
            endcase
        end

        if (clr) begin
            s_next.count = mpc_pkg::ZERO;
            s_next.dir_down = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    generate
        for (genvar g = 0; g < mpc_pkg::NUM_CMP; g++) begin : g_cmp
            logic [31:0] buf_wdat;
            assign cmp_wr[g] = wr && wb_adr_i == mpc_pkg::ADR_CMP_BASE
                + 8'(g) * mpc_pkg::ADR_STEP;
            assign buf_wdat = mpc_pkg::merge({16'h0000, cmp_buf[g]}, wb_dat_i, wb_sel_i);
            mpc_cmp_unit u_cmp (
                .ref_clk(ref_clk),
                .rst(rst),
                .buf_wr(cmp_wr[g]),
                .buf_data(buf_wdat[mpc_pkg::CW-1:0]),
                .defer(s_reg.defer),
                .group_load(load_mask[g]),
                .advance(advance),
                .count(s_reg.count & mx),
                .count_next(cnt_next),
                .buffer(cmp_buf[g]),
                .latch(cmp_latch[g]),
                .match(cmp_match[g])
            );
        end
    endgenerate

    assign wb_dat_o = s_reg.dat;
    assign wb_ack_o = s_reg.ack;
    assign cmp_event = cmp_match;
    // request only with own enable and the global enable
    assign irq = s_reg.glob_ie && |({s_reg.cmp_flag, s_reg.wrap_flag} & s_reg.ie);
endmodule

// ---- sim/mpc_timer_chk.sv ----
// port checker for the multimode period counter
// assumes a bind onto mpc_timer and byte selects all set on writes
`timescale 1ns/1ps
module mpc_timer_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq,
    input wire logic [mpc_pkg::NUM_CMP-1:0] cmp_event
);
    logic [31:0] ctl_reg;
    logic [31:0] ie_reg;
    logic wr;
    assign wr = wb_ack_o & wb_we_i & wb_cyc_i;
    // shadow of control and enable writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_reg <= 32'h0;
            ie_reg <= 32'h0;
        end else if (wr && wb_adr_i == mpc_pkg::ADR_CTRL) begin
            ctl_reg <= wb_dat_i;
        end else if (wr && wb_adr_i == mpc_pkg::ADR_IE) begin
            ie_reg <= wb_dat_i;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read bits set");
    a_clr_reads0: assert property (wb_ack_o && !wb_we_i && wb_adr_i == mpc_pkg::ADR_CTRL
        |-> !wb_dat_o[4]) else $error("clear bit reads one");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h14
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_irq_gated: assert property (irq |-> ctl_reg[5] && ie_reg[7:0] != 8'h0)
        else $error("irq without enables");
    a_ev_spacing: assert property (|cmp_event |=> (cmp_event == 7'h0) [*3])
        else $error("events closer than timer clock");
    a_stop_quiet: assert property (ctl_reg[1:0] == 2'h0 && $past(ctl_reg[1:0], 2) == 2'h0
        |-> cmp_event == 7'h0) else $error("event in stop mode");
endmodule
bind mpc_timer mpc_timer_chk chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .cmp_event);

// ---- sim/tb_multimode_period_counter.sv ----
// self-checking bench for the multimode period counter
// assumes mpc_timer with a timer clock of ref_clk/4
`timescale 1ns/1ps
module tb_multimode_period_counter;
    logic ref_clk, rst, cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r, rv;
    logic [6:0] ev;
    int fail_count = 0, n_checks = 0, cyc_n = 0, seed = 14;
    int t1, t2, p, c, l, i, q, j;
    int mx[4] = '{65535, 4095, 1023, 255};
    localparam logic [7:0] CB = mpc_pkg::ADR_CMP_BASE;
    mpc_timer uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .irq(irq), .cmp_event(ev));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 60000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat_w <= d;
        // no timeout of its own: if ack never comes, only the cycle ceiling ends this wait
        do @(posedge ref_clk); while (ack !== 1'b1);
        rv = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic evw(input int b, output int t);
        do @(posedge ref_clk); while (ev[b] !== 1'b1);
        t = cyc_n;
    endtask
    // model: ref_clk edges from the match at the old period to the match
    // at a smaller new one; nj is the edge of the latch change after that match
    function automatic int roll_gap(input int nq, input int nj);
        int extra;
        extra = (nj % 4 >= 2) ? 1 : 0;
        return 4 * (nq + nj / 4 + 1 + extra);
    endfunction
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] n, input logic x);
        return {27'h0, x, n, m};
    endfunction
    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
        adr = 8'h0; sel = 4'h0; dat_w = 32'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            check(rv, 32'h0);
        end
        bus(1'b1, 8'h14, 32'hffff);
        bus(1'b0, 8'h14, 32'h0);
        check(rv, 32'h0);
        for (l = 3; l >= 1; l--) begin
            bus(1'b1, CB, 32'h10);
            bus(1'b1, 8'h0, ctl(2'h2, l[1:0], 1'b1));
            evw(0, t1);
            evw(0, t2);
            check(t2 - t1, 4 * (mx[l] + 1));
        end
        bus(1'b1, 8'h0, ctl(2'h2, 2'h3, 1'b1));
        for (i = 1; i < 7; i++) begin
            bus(1'b1, CB + 8'(4 * i), 32'(16 + i));
            evw(0, t1);
            evw(i, t2);
            check(t2 - t1, 4 * i);
        end
        bus(1'b1, 8'h0, ctl(2'h0, 2'h0, 1'b0));
        bus(1'b1, mpc_pkg::ADR_COUNT, 32'hfffe);
        bus(1'b1, mpc_pkg::ADR_STATUS, 32'h1ff);
        bus(1'b1, 8'h0, ctl(2'h2, 2'h0, 1'b0));
        repeat (40) @(posedge ref_clk);
        bus(1'b1, 8'h0, ctl(2'h0, 2'h0, 1'b0));
        bus(1'b0, mpc_pkg::ADR_STATUS, 32'h0);
        check(rv[0], 1'b1);
        bus(1'b0, mpc_pkg::ADR_COUNT, 32'h0);
        check(32'(rv < 32'h20), 32'h1);
        check(irq, 1'b0);
        bus(1'b1, mpc_pkg::ADR_IE, 32'h1);
        @(posedge ref_clk);
        check(irq, 1'b0);
        bus(1'b1, 8'h0, 32'h20);
        @(posedge ref_clk);
        check(irq, 1'b1);
        bus(1'b1, mpc_pkg::ADR_STATUS, 32'h1);
        @(posedge ref_clk);
        check(irq, 1'b0);
        bus(1'b1, CB, 32'h1ff);
        bus(1'b1, 8'h0, ctl(2'h0, 2'h3, 1'b0));
        bus(1'b1, mpc_pkg::ADR_COUNT, 32'h5);
        bus(1'b1, 8'h0, ctl(2'h1, 2'h3, 1'b0));
        repeat (20) @(posedge ref_clk);
        bus(1'b1, 8'h0, ctl(2'h0, 2'h3, 1'b0));
        bus(1'b0, mpc_pkg::ADR_COUNT, 32'h0);
        check(rv, 32'h0);
        bus(1'b1, CB + 8'h4, 32'h10);
        bus(1'b1, 8'h0, ctl(2'h3, 2'h3, 1'b1));
        evw(1, t1);
        evw(1, t2);
        check(t2 - t1, 4 * (mx[3] + 1));
        p = 4 + ($random(seed) & 15);
        bus(1'b1, CB, 32'(p));
        bus(1'b1, 8'h0, ctl(2'h1, 2'h0, 1'b1));
        evw(0, t1);
        evw(0, t2);
        check(t2 - t1, 4 * (p + 1));
        repeat (8) @(posedge ref_clk);
        bus(1'b1, CB, 32'(p + 5));
        evw(0, t1);
        evw(0, t2);
        check(t2 - t1, 4 * (p + 6));
        bus(1'b1, CB, 32'(p));
        bus(1'b1, 8'h0, ctl(2'h3, 2'h0, 1'b1));
        evw(0, t1);
        evw(0, t2);
        check(t2 - t1, 8 * p);
        repeat (8) @(posedge ref_clk);
        bus(1'b1, CB, 32'(p + 3));
        evw(0, t1);
        check(t1 - t2, 4 * (2 * p + 3));
        repeat (8) @(posedge ref_clk);
        bus(1'b1, 8'h0, ctl(2'h0, 2'h0, 1'b0));
        bus(1'b0, mpc_pkg::ADR_STATUS, 32'h0);
        check(rv[8], 1'b1);
        bus(1'b0, mpc_pkg::ADR_COUNT, 32'h0);
        c = int'(rv);
        bus(1'b1, 8'h0, ctl(2'h3, 2'h0, 1'b0));
        repeat (8) @(posedge ref_clk);
        bus(1'b1, 8'h0, ctl(2'h0, 2'h0, 1'b0));
        bus(1'b0, mpc_pkg::ADR_COUNT, 32'h0);
        check(32'(int'(rv) < c), 32'h1);
        bus(1'b1, 8'h0, ctl(2'h0, 2'h0, 1'b1));
        bus(1'b0, mpc_pkg::ADR_STATUS, 32'h0);
        check(rv[8], 1'b0);
        bus(1'b0, mpc_pkg::ADR_COUNT, 32'h0);
        check(rv, 32'h0);
        // smaller period in up mode, change seen in high and in low phase
        for (i = 0; i < 3; i++) begin
            q = 4 + ($random(seed) & 7);
            bus(1'b1, CB, 32'h28);
            bus(1'b1, 8'h0, ctl(2'h1, 2'h0, 1'b1));
            evw(0, t1);
            repeat (60 + i + (i > 0)) @(posedge ref_clk);
            bus(1'b1, CB, 32'(q));
            j = cyc_n - t1 + 1;
            evw(0, t2);
            check(t2 - t1, roll_gap(q, j));
        end
        wrap_up();
    end
endmodule
